// ==== olb_pkg.sv ====
// Purpose : shared constants and types of the on-off keyed button link
// Assumes : 100 MHz system clock, one clock domain
// Notes   : bit timing is built from one third of a bit period

package olb_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_NS    = 10;
    localparam int THIRD_NS  = 500000;                   // one third of a bit period
    localparam int THIRD_CYC = (THIRD_NS + CLK_NS - 1) / CLK_NS;
    localparam int TMR_W     = 20;

    // ----------------------------------------------------------------
    // frame layout
    // ----------------------------------------------------------------
    localparam logic [15:0] PREAMBLE   = 16'hfffe;
    localparam int          FRAME_BITS = 40;             // two preamble bytes, three data bytes
    localparam int          DATA_REPS  = 3;
    localparam logic [3:0]  BATT_OK    = 4'h0;
    localparam logic [3:0]  BATT_LOW   = 4'hf;
    localparam logic [3:0]  BTN_CODE0  = 4'h1;
    localparam logic [3:0]  BTN_CODE1  = 4'h3;
    localparam logic [3:0]  BTN_CODE2  = 4'h7;
    localparam logic [3:0]  BTN_CODE3  = 4'hf;
    localparam int          FIFO_DEPTH = 16;
    localparam int          FIFO_WIDTH = 8;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        TX_SLEEP = 2'b00,
        TX_ON    = 2'b01,
        TX_OFF   = 2'b10
    } olb_tx_st_t;

    typedef enum logic [1:0] {
        RX_HUNT = 2'b00,
        RX_DATA = 2'b01,
        RX_PUSH = 2'b10
    } olb_rx_st_t;

    typedef struct packed {
        logic [3:0] batt;
        logic [3:0] code;
    } olb_byte_t;

    typedef struct packed {
        olb_tx_st_t                tx_st;
        logic [TMR_W-1:0]          tx_tmr;
        logic [FRAME_BITS-1:0]     tx_frame;
        logic [5:0]                tx_cnt;
        logic                      tx_key;
        logic [3:0]                btn_s1;
        logic [3:0]                btn_s2;
        logic [3:0]                btn_d;
        logic                      lb_s1;
        logic                      lb_s2;
        olb_rx_st_t                rx_st;
        logic [TMR_W-1:0]          rx_tmr;
        logic                      rx_s1;
        logic                      rx_s2;
        logic                      rx_d;
        logic                      rs_s1;
        logic                      rs_s2;
        logic                      rse_s1;
        logic                      rse_s2;
        logic [7:0]                rx_shift;
        logic [2:0]                rx_bits;
        logic                      led_hi;
        logic                      led_lo;
        logic                      led_batt;
        olb_byte_t                 push_data;
    } olb_state_t;

endpackage

// ==== olb_link.sv ====
// Purpose : button transmitter and pulse-width receiver of a one-way keyed link
// Assumes : single clock, pins pass two flops, active-low button pins
// Notes   : received codes queue in a small fifo toward the user

module olb_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    input  wire logic         i_sys_clk,   // system clock
    input  wire logic         i_rst_b,     // sync reset, active low
    input  wire logic         i_in_valid,  // write request
    output logic              o_in_ready,  // room for a word
    input  wire logic [W-1:0] i_in_data,   // write word
    output logic              o_out_valid, // word available
    input  wire logic         i_out_ready, // reader takes word
    output logic [W-1:0]      o_out_data   // head word
);
    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW:0]         wr;
        logic [AW:0]         rd;
    } olb_fifo_state_t;

    olb_fifo_state_t st_ff;
    olb_fifo_state_t nxt_st;
    logic            full;
    logic            empty;

    assign full        = (st_ff.wr[AW] != st_ff.rd[AW]) && (st_ff.wr[AW-1:0] == st_ff.rd[AW-1:0]);
    assign empty       = (st_ff.wr == st_ff.rd);
    assign o_in_ready  = !full;
    assign o_out_valid = !empty;
    assign o_out_data  = st_ff.mem[st_ff.rd[AW-1:0]];

    always_comb begin
        nxt_st = st_ff;
        if (i_in_valid && !full) begin
            nxt_st.mem[st_ff.wr[AW-1:0]] = i_in_data;
            nxt_st.wr = st_ff.wr + 1'b1;
        end
        if (i_out_ready && !empty) begin
            nxt_st.rd = st_ff.rd + 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule

module olb_link #(
    parameter int P_THIRD_CYC = olb_pkg::THIRD_CYC   // cycles in one third of a bit
) (
    input  wire logic       i_sys_clk,    // system clock
    input  wire logic       i_rst_b,      // sync reset, active low
    input  wire logic [3:0] i_btn_n,      // button pins, low when pressed
    input  wire logic       i_low_batt,   // detector: supply below threshold
    output logic            o_tx_key,     // carrier on
    output logic            o_tx_busy,    // message in flight
    input  wire logic       i_rx_data,    // demodulated data pin
    input  wire logic       i_rssi_ok,    // strength comparator: strong carrier
    input  wire logic       i_rssi_en,    // use strength gate
    output logic            o_led_hi,     // button number bit 1
    output logic            o_led_lo,     // button number bit 0
    output logic            o_led_batt,   // remote reports low battery
    output logic            o_code_valid, // received byte available
    input  wire logic       i_code_ready, // user takes the byte
    output logic [7:0]      o_code_data   // received byte
);
    localparam int TW = olb_pkg::TMR_W;
    localparam logic [TW-1:0] T1   = TW'(P_THIRD_CYC);
    localparam logic [TW-1:0] T2   = TW'(2 * P_THIRD_CYC);
    localparam logic [TW-1:0] LONG = TW'((3 * P_THIRD_CYC) / 2);
    localparam logic [5:0]    LAST = 6'(olb_pkg::FRAME_BITS - 1);

    olb_pkg::olb_state_t st_ff;
    olb_pkg::olb_state_t nxt_st;
    logic [3:0]          btn_fall;
    logic [3:0]          code;
    olb_pkg::olb_byte_t  tx_byte;
    logic                rx_edge;
    logic                rx_acc;
    logic                rx_fall;
    logic                rx_bit;
    logic [7:0]          rx_next;
    logic                fifo_ready;
    logic                code_ok;
    logic [1:0]          code_idx;

    // ----------------------------------------------------------------
    // transmit helpers
    // ----------------------------------------------------------------
    assign btn_fall = st_ff.btn_d & ~st_ff.btn_s2;

    always_comb begin
        code = olb_pkg::BTN_CODE0;
        for (int i = 3; i >= 0; i--) begin
            if (btn_fall[i]) begin
                unique case (i)
                    0: code = olb_pkg::BTN_CODE0;
                    1: code = olb_pkg::BTN_CODE1;
                    2: code = olb_pkg::BTN_CODE2;
                    default: code = olb_pkg::BTN_CODE3;
                endcase
            end
        end
    end

    assign tx_byte = '{batt: st_ff.lb_s2 ? olb_pkg::BATT_LOW : olb_pkg::BATT_OK, code: code};

    // ----------------------------------------------------------------
    // receive helpers
    // ----------------------------------------------------------------
    assign rx_edge = st_ff.rx_s2 ^ st_ff.rx_d;
    assign rx_acc  = rx_edge && (!st_ff.rse_s2 || st_ff.rs_s2);
    assign rx_fall = rx_acc && st_ff.rx_d && !st_ff.rx_s2;
    // timer reads one below the pulse length, so the compare is inclusive
    assign rx_bit  = (st_ff.rx_tmr >= LONG);
    assign rx_next = {st_ff.rx_shift[6:0], rx_bit};

    always_comb begin
        code_ok  = 1'b1;
        code_idx = 2'd0;
        unique case (rx_next[3:0])
            olb_pkg::BTN_CODE0: code_idx = 2'd0;
            olb_pkg::BTN_CODE1: code_idx = 2'd1;
            olb_pkg::BTN_CODE2: code_idx = 2'd2;
            olb_pkg::BTN_CODE3: code_idx = 2'd3;
            default: code_ok = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        nxt_st        = st_ff;
        nxt_st.btn_s1 = i_btn_n;
        nxt_st.btn_s2 = st_ff.btn_s1;
        nxt_st.btn_d  = st_ff.btn_s2;
        nxt_st.lb_s1  = i_low_batt;
        nxt_st.lb_s2  = st_ff.lb_s1;
        nxt_st.rx_s1  = i_rx_data;
        nxt_st.rx_s2  = st_ff.rx_s1;
        nxt_st.rx_d   = st_ff.rx_s2;
        nxt_st.rs_s1  = i_rssi_ok;
        nxt_st.rs_s2  = st_ff.rs_s1;
        nxt_st.rse_s1 = i_rssi_en;
        nxt_st.rse_s2 = st_ff.rse_s1;

        unique case (st_ff.tx_st)
            olb_pkg::TX_SLEEP: begin
                if (|btn_fall) begin
                    nxt_st.tx_frame = {olb_pkg::PREAMBLE, {olb_pkg::DATA_REPS{tx_byte}}};
                    nxt_st.tx_key   = 1'b1;
                    nxt_st.tx_tmr   = olb_pkg::PREAMBLE[15] ? T2 : T1;
                    nxt_st.tx_cnt   = '0;
                    nxt_st.tx_st    = olb_pkg::TX_ON;
                end
            end
            olb_pkg::TX_ON: begin
                if (st_ff.tx_tmr == TW'(1)) begin
                    nxt_st.tx_key = 1'b0;
                    nxt_st.tx_tmr = st_ff.tx_frame[39] ? T1 : T2;
                    nxt_st.tx_st  = olb_pkg::TX_OFF;
                end else begin
                    nxt_st.tx_tmr = st_ff.tx_tmr - TW'(1);
                end
            end
            olb_pkg::TX_OFF: begin
                if (st_ff.tx_tmr != TW'(1)) begin
                    nxt_st.tx_tmr = st_ff.tx_tmr - TW'(1);
                end else if (st_ff.tx_cnt == LAST) begin
                    nxt_st.tx_st = olb_pkg::TX_SLEEP;
                end else begin
                    // next bit chosen only once the off phase is spent
                    nxt_st.tx_frame = {st_ff.tx_frame[38:0], 1'b0};
                    nxt_st.tx_cnt   = st_ff.tx_cnt + 6'd1;
                    nxt_st.tx_key   = 1'b1;
                    nxt_st.tx_tmr   = st_ff.tx_frame[38] ? T2 : T1;
                    nxt_st.tx_st    = olb_pkg::TX_ON;
                end
            end
            default: nxt_st.tx_st = olb_pkg::TX_SLEEP;
        endcase

        // saturate so a long idle line never wraps into a short pulse
        if (rx_edge) begin
            nxt_st.rx_tmr = '0;
        end else if (st_ff.rx_tmr != '1) begin
            nxt_st.rx_tmr = st_ff.rx_tmr + TW'(1);
        end

        unique case (st_ff.rx_st)
            olb_pkg::RX_HUNT: begin
                if (rx_fall) begin
                    nxt_st.rx_shift = rx_next;
                    if (rx_next == olb_pkg::PREAMBLE[7:0]) begin
                        nxt_st.rx_bits = '0;
                        nxt_st.rx_st   = olb_pkg::RX_DATA;
                    end
                end
            end
            olb_pkg::RX_DATA: begin
                if (rx_fall) begin
                    nxt_st.rx_shift = rx_next;
                    nxt_st.rx_bits  = st_ff.rx_bits + 3'd1;
                    if (st_ff.rx_bits == 3'd7) begin
                        if (code_ok) begin
                            nxt_st.led_hi    = code_idx[1];
                            nxt_st.led_lo    = code_idx[0];
                            nxt_st.led_batt  = (rx_next[7:4] != olb_pkg::BATT_OK);
                            nxt_st.push_data = rx_next;
                            nxt_st.rx_st     = olb_pkg::RX_PUSH;
                        end else begin
                            nxt_st.rx_shift = '0;
                            nxt_st.rx_st    = olb_pkg::RX_HUNT;
                        end
                    end
                end
            end
            olb_pkg::RX_PUSH: begin
                // edges are dropped while the fifo is full
                if (fifo_ready) begin
                    nxt_st.rx_shift = '0;
                    nxt_st.rx_st    = olb_pkg::RX_HUNT;
                end
            end
            default: nxt_st.rx_st = olb_pkg::RX_HUNT;
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            st_ff        <= '0;
            st_ff.btn_s1 <= 4'hf;
            st_ff.btn_s2 <= 4'hf;
            st_ff.btn_d  <= 4'hf;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ----------------------------------------------------------------
    // outputs and code queue
    // ----------------------------------------------------------------
    assign o_tx_key   = st_ff.tx_key;
    assign o_tx_busy  = (st_ff.tx_st != olb_pkg::TX_SLEEP);
    assign o_led_hi   = st_ff.led_hi;
    assign o_led_lo   = st_ff.led_lo;
    assign o_led_batt = st_ff.led_batt;

    olb_fifo #(
        .W (olb_pkg::FIFO_WIDTH),
        .D (olb_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_sys_clk   (i_sys_clk),
        .i_rst_b     (i_rst_b),
        .i_in_valid  (st_ff.rx_st == olb_pkg::RX_PUSH),
        .o_in_ready  (fifo_ready),
        .i_in_data   (st_ff.push_data),
        .o_out_valid (o_code_valid),
        .i_out_ready (i_code_ready),
        .o_out_data  (o_code_data)
    );

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic [TW-1:0] ast_on_ff;
    logic [TW-1:0] ast_off_ff;

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            ast_on_ff  <= '0;
            ast_off_ff <= '0;
        end else begin
            ast_on_ff  <= o_tx_key ? ast_on_ff + TW'(1) : '0;
            ast_off_ff <= (st_ff.tx_st == olb_pkg::TX_OFF) ? ast_off_ff + TW'(1) : '0;
        end
    end

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);

    sequence seq_tx_start;
        st_ff.tx_st == olb_pkg::TX_SLEEP && |btn_fall;
    endsequence

    sequence seq_rx_last_bit;
        st_ff.rx_st == olb_pkg::RX_DATA && rx_fall && st_ff.rx_bits == 3'd7;
    endsequence

    AST_ON_LEN: assert property ($fell(o_tx_key) |-> ast_on_ff == (st_ff.tx_frame[39] ? T2 : T1))
        else $error("carrier on phase has wrong length");
    AST_OFF_LEN: assert property ($rose(o_tx_key) && $past(st_ff.tx_st) == olb_pkg::TX_OFF
                                  |-> ast_off_ff == ($past(st_ff.tx_frame[39]) ? T1 : T2))
        else $error("carrier off phase has wrong length");
    AST_PREAMBLE: assert property (seq_tx_start |=> st_ff.tx_frame[39:24] == olb_pkg::PREAMBLE && o_tx_key)
        else $error("message does not open with preamble");
    AST_REPEAT: assert property (seq_tx_start |=> st_ff.tx_frame[23:16] == st_ff.tx_frame[15:8]
                                 && st_ff.tx_frame[15:8] == st_ff.tx_frame[7:0])
        else $error("data byte not repeated three times");
    AST_BATT: assert property (seq_tx_start |=> st_ff.tx_frame[7:4] ==
                               ($past(st_ff.lb_s2) ? olb_pkg::BATT_LOW : olb_pkg::BATT_OK))
        else $error("battery field does not follow detector");
    AST_WAKE: assert property (seq_tx_start |=> o_tx_busy ##1 o_tx_busy)
        else $error("button press did not wake transmitter");
    AST_RX_RESTART: assert property (rx_edge |=> st_ff.rx_tmr == '0)
        else $error("receive timer not restarted on edge");
    AST_BIT_VALUE: assert property (st_ff.rx_st == olb_pkg::RX_HUNT && rx_fall
                                    |=> st_ff.rx_shift[0] == ($past(st_ff.rx_tmr) >= LONG))
        else $error("bit value does not follow pulse length");
    AST_HUNT_HIT: assert property (st_ff.rx_st == olb_pkg::RX_HUNT && rx_fall && rx_next == olb_pkg::PREAMBLE[7:0]
                                   |=> st_ff.rx_st == olb_pkg::RX_DATA)
        else $error("preamble byte not recognised");
    AST_BAD_CODE: assert property ((seq_rx_last_bit and !code_ok) |=> st_ff.rx_st == olb_pkg::RX_HUNT)
        else $error("invalid code not dropped");
    AST_LEDS: assert property ((seq_rx_last_bit and code_ok) |=> {o_led_hi, o_led_lo} == $past(code_idx)
                               && o_led_batt == ($past(rx_next[7:4]) != olb_pkg::BATT_OK))
        else $error("indicators do not match received code");
    AST_WEAK_EDGE: assert property (rx_edge && st_ff.rse_s2 && !st_ff.rs_s2 |=> $stable(st_ff.rx_shift))
        else $error("weak edge was decoded");
endmodule

// ==== olb_remote.sv ====
// Purpose : far end of the keyed link, a pulse-width source and a key decoder
// Assumes : one clock; demodulator output sits low while there is no carrier
// Notes   : pulse widths are given per call, so a scenario can skew them

module olb_remote #(
    parameter int T = 20                 // cycles in one third of a bit
) (
    input  wire logic  i_sys_clk,        // system clock
    input  wire logic  i_tx_key,         // carrier keyed by the block
    output logic       o_rx_data,        // demodulated data toward the block
    output logic       o_byte_stb,       // one decoded byte this cycle
    output logic [7:0] o_byte,           // decoded byte, msb first on air
    output int         o_width_err       // key phases of a wrong length
);
    timeunit 1ns;
    timeprecision 1ps;

    int   hi_cnt  = 0;
    int   lo_cnt  = 4 * T;
    int   last_hi = 0;
    int   nbits   = 0;
    logic key_d   = 1'b0;

    initial begin
        o_rx_data   = 1'b0;
        o_byte_stb  = 1'b0;
        o_byte      = 8'h00;
        o_width_err = 0;
    end

    // ------------------------------------------------------------
    // key decoder
    // ------------------------------------------------------------
    always @(posedge i_sys_clk) begin
        key_d      <= i_tx_key;
        o_byte_stb <= 1'b0;
        if (i_tx_key && !key_d) begin
            hi_cnt <= 1;
            if (lo_cnt < 4 * T && lo_cnt != 3 * T - last_hi) o_width_err <= o_width_err + 1;
        end else if (i_tx_key) begin
            hi_cnt <= hi_cnt + 1;
        end else if (key_d) begin
            lo_cnt     <= 1;
            last_hi    <= hi_cnt;
            if (hi_cnt != T && hi_cnt != 2 * T) o_width_err <= o_width_err + 1;
            o_byte     <= {o_byte[6:0], hi_cnt > 3 * T / 2};
            o_byte_stb <= (nbits == 7);
            nbits      <= (nbits == 7) ? 0 : nbits + 1;
        end else begin
            lo_cnt <= lo_cnt + 1;
            // a long silence ends the frame, so byte framing restarts
            if (lo_cnt > 4 * T) nbits <= 0;
        end
    end

    // ------------------------------------------------------------
    // pulse source, line low between pulses and frames
    // ------------------------------------------------------------
    task automatic send_bits(input logic [31:0] bits, input int n, input int hi1, input int hi0);
        int hi;
        for (int i = n - 1; i >= 0; i--) begin
            hi = bits[i] ? hi1 : hi0;
            @(posedge i_sys_clk);
            o_rx_data <= 1'b1;
            repeat (hi) @(posedge i_sys_clk);
            o_rx_data <= 1'b0;
            repeat (3 * T - hi - 1) @(posedge i_sys_clk);
        end
    endtask
endmodule

// ==== testbench.sv ====
// Purpose : self-checking bench of the keyed button link
// Assumes : a third of 20 cycles, remote model on the far side
// Notes   : drivers queue expected bytes, a monitor compares them on arrival

`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin fail_count++; $display("ERROR %s expected %h seen %h", nm, ex, got); end end

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int T = 20;

    logic       i_sys_clk  = 1'b0;
    logic       i_rst_b    = 1'b0;
    logic [3:0] btn_n      = 4'hf;
    logic       low_batt   = 1'b0;
    logic       rssi_ok    = 1'b1;
    logic       rssi_en    = 1'b0;
    logic       code_ready = 1'b0;
    logic       pop_en     = 1'b0;
    logic       tx_key;
    logic       tx_busy;
    logic       rx_data;
    logic       led_hi;
    logic       led_lo;
    logic       led_batt;
    logic       code_valid;
    logic [7:0] code_data;
    logic       byte_stb;
    logic [7:0] tx_byte;
    logic [7:0] e_tx;
    logic [7:0] e_rx;
    int         width_err;
    int         fail_count = 0;
    int         checked    = 0;
    logic [7:0] exp_tx[$];
    logic [7:0] exp_rx[$];
    logic [3:0] codes[4]   = '{4'h1, 4'h3, 4'h7, 4'hf};

    olb_link #(.P_THIRD_CYC(T)) u_olb_link (
        .i_sys_clk    (i_sys_clk),
        .i_rst_b      (i_rst_b),
        .i_btn_n      (btn_n),
        .i_low_batt   (low_batt),
        .o_tx_key     (tx_key),
        .o_tx_busy    (tx_busy),
        .i_rx_data    (rx_data),
        .i_rssi_ok    (rssi_ok),
        .i_rssi_en    (rssi_en),
        .o_led_hi     (led_hi),
        .o_led_lo     (led_lo),
        .o_led_batt   (led_batt),
        .o_code_valid (code_valid),
        .i_code_ready (code_ready),
        .o_code_data  (code_data)
    );

    olb_remote #(.T(T)) u_olb_remote (
        .i_sys_clk   (i_sys_clk),
        .i_tx_key    (tx_key),
        .o_rx_data   (rx_data),
        .o_byte_stb  (byte_stb),
        .o_byte      (tx_byte),
        .o_width_err (width_err)
    );

    initial begin
        forever #5 i_sys_clk = ~i_sys_clk;
    end

    // ------------------------------------------------------------
    // monitor and user side of the fifo
    // ------------------------------------------------------------
    always @(posedge i_sys_clk) begin
        code_ready <= pop_en && ($urandom % 2 == 1);
        if (byte_stb === 1'b1) begin
            e_tx = exp_tx.size() ? exp_tx.pop_front() : 8'hxx;
            `CHK("tx byte", e_tx, tx_byte)
        end
        if (code_valid === 1'b1 && code_ready === 1'b1) begin
            e_rx = exp_rx.size() ? exp_rx.pop_front() : 8'hxx;
            `CHK("rx word", e_rx, code_data)
        end
    end

    function automatic logic [1:0] btn_num(input logic [3:0] c);
        return (c == 4'hf) ? 2'h3 : (c == 4'h7) ? 2'h2 : (c == 4'h3) ? 2'h1 : 2'h0;
    endfunction

    function automatic logic [7:0] rnd_byte(input int b);
        return {($urandom % 2) ? 4'($urandom % 15 + 1) : 4'h0, codes[b]};
    endfunction

    // ------------------------------------------------------------
    // drivers
    // ------------------------------------------------------------
    task automatic press(input int b, input logic lb, input int other);
        logic [7:0] d;
        int         n;
        d = {lb ? 4'hf : 4'h0, codes[b]};
        exp_tx.push_back(8'hff);
        exp_tx.push_back(8'hfe);
        repeat (3) exp_tx.push_back(d);
        low_batt <= lb;
        @(posedge i_sys_clk);
        btn_n[b] <= 1'b0;
        for (n = 0; n < 20 && tx_busy !== 1'b1; n++) @(posedge i_sys_clk);
        `CHK("busy on press", 1'b1, tx_busy)
        if (other >= 0) btn_n[other] <= 1'b0;
        repeat (10) @(posedge i_sys_clk);
        btn_n <= 4'hf;
        for (n = 0; n < 130 * T && tx_busy !== 1'b0; n++) @(posedge i_sys_clk);
        repeat (6 * T) @(posedge i_sys_clk);
        `CHK("tx bytes left", 0, exp_tx.size())
        `CHK("busy after frame", 1'b0, tx_busy)
    endtask

    // mode 1 valid code, 0 refused or dropped with leds held
    task automatic rx_frame(input logic [7:0] d, input int hi1, input int hi0, input int mode);
        logic [2:0] old;
        old = {led_hi, led_lo, led_batt};
        if (mode == 1) exp_rx.push_back(d);
        u_olb_remote.send_bits({5'h00, 3'($urandom), 16'hfffe, d}, 27, hi1, hi0);
        repeat (2 * T) @(posedge i_sys_clk);
        if (mode == 1) `CHK("leds", {btn_num(d[3:0]), d[7:4] != 4'h0}, {led_hi, led_lo, led_batt})
        else if (mode == 0) `CHK("leds held", old, {led_hi, led_lo, led_batt})
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        int n;
        void'($urandom(32'h69e801e2));
        repeat (8) @(posedge i_sys_clk);
        i_rst_b <= 1'b1;
        @(posedge i_sys_clk);
        `CHK("reset outputs", 6'h00, {tx_key, tx_busy, led_hi, led_lo, led_batt, code_valid})
        for (int b = 0; b < 4; b++) press(b, 1'($urandom), (b == 1) ? 3 : -1);
        pop_en <= 1'b1;
        for (int b = 0; b < 4; b++) rx_frame(rnd_byte(b), 2 * T, T, 1);
        rx_frame(8'h05, 2 * T, T, 0);
        rx_frame(8'h0e, 2 * T, T, 0);
        rx_frame(8'hf7, 34, 27, 1);
        rx_frame(8'h73, 31, 30, 1);
        rssi_en <= 1'b1;
        rssi_ok <= 1'b0;
        rx_frame(8'h01, 2 * T, T, 0);
        rssi_ok <= 1'b1;
        rx_frame(8'h03, 2 * T, T, 1);
        rssi_en <= 1'b0;
        // fill the fifo with no reader; the next word waits for room, the one after is lost
        for (n = 0; n < 100 && code_valid !== 1'b0; n++) @(posedge i_sys_clk);
        pop_en <= 1'b0;
        repeat (16) rx_frame(rnd_byte($urandom % 4), 2 * T, T, 1);
        rx_frame(8'h01, 2 * T, T, 1);
        rx_frame(8'h07, 2 * T, T, 0);
        `CHK("fifo full", 1'b1, code_valid)
        pop_en <= 1'b1;
        for (n = 0; n < 400 && code_valid !== 1'b0; n++) @(posedge i_sys_clk);
        rx_frame(rnd_byte(0), 2 * T, T, 1);
        for (n = 0; n < 100 && code_valid !== 1'b0; n++) @(posedge i_sys_clk);
        `CHK("rx words left", 0, exp_rx.size())
        `CHK("key phase widths", 0, width_err)
        report_and_stop();
    end

    initial begin
        repeat (90000) @(posedge i_sys_clk);
        fail_count++;
        $display("ERROR watchdog expected finish seen hang");
        report_and_stop();
    end
endmodule
